// ### hdl/ssp_slave.sv
// spi slave port: shift engine, buffers, flags and interrupt request
`timescale 1ns/1ps
module ssp_slave
	import ssp_pkg::*;
#(
	parameter int DW = SSP_DW
) (
	input  wire logic                 clk_sys_in,             // system clock
	input  wire logic                 srst_in,                // sync reset
	input  wire logic                 spi_sck_in,             // spi clock pin
	input  wire logic                 spi_ss_n_in,            // slave select pin
	input  wire logic                 spi_mosi_in,            // master data pin
	output logic                      spi_miso_out,           // slave data pin
	output logic                      spi_miso_oe_out,        // miso drive enable
	input  wire logic                 miso_dir_out_in,        // port direction output
	input  wire logic                 enable_in,              // port enable
	input  wire logic [1:0]           transfer_mode_in,       // polarity and phase
	input  wire logic                 bit_order_select_in,    // 1 lsb first
	input  wire logic                 buffer_mode_enable_in,  // buffered operation
	input  wire logic                 buffer_wait_receive_in, // direct first write
	input  wire logic                 data_wr_in,             // data write strobe
	input  wire logic [DW-1:0]        data_wdata_in,          // data to send
	input  wire logic                 data_rd_in,             // receive pop strobe
	output logic      [DW-1:0]        data_rdata_out,         // oldest received byte
	output logic      [1:0]           rx_count_out,           // bytes held
	input  wire logic [SSP_FLAGS-1:0] flag_clear_in,          // flag clear strobes
	input  wire logic [SSP_FLAGS-1:0] irq_enable_in,          // interrupt enables
	output logic      [SSP_FLAGS-1:0] flags_out,              // sticky flags
	output logic                      irq_out                 // combined request
);
	localparam int CW = $clog2(DW);
	localparam logic [CW-1:0] CNT_LAST = CW'(DW - 1);

	function automatic logic [DW-1:0] shift_in(input logic [DW-1:0] v,
		input logic b, input logic lsb);
		shift_in = lsb ? {b, v[DW-1:1]} : {v[DW-2:0], b};
	endfunction

	function automatic logic out_bit(input logic [DW-1:0] v, input logic lsb);
		out_bit = lsb ? v[0] : v[DW-1];
	endfunction

	logic [2:0]           pin_s;
	logic                 sck_prev_q;
	logic                 ss_prev_q;
	ssp_state_e           st_q;
	ssp_state_e           st_d;
	logic [CW-1:0]        cnt_q;
	logic [DW-1:0]        sh_q;
	logic [DW-1:0]        sh_d;
	logic [DW-1:0]        txb_q;
	logic                 txfull_q;
	logic                 loaded_q;
	logic                 miso_q;
	logic                 done_q1;
	logic                 done_q2;
	logic                 empty_q1;
	logic                 empty_q2;
	logic [SSP_FLAGS-1:0] flag_q;
	logic [SSP_FLAGS-1:0] flag_set;
	logic [SSP_FLAGS-1:0] flag_clr;
	logic [DW-1:0]        rx_mem_q [SSP_RX_DEPTH];
	logic [DW-1:0]        rx_mem_d [SSP_RX_DEPTH];
	logic [1:0]           rx_cnt_q;
	logic [1:0]           rx_cnt_d;

	// pins are sampled only; nothing here drives select, sck or mosi
	// select resets to its idle high level, so no false select or select edge follows reset
	ssp_sync #(
		.W       (3),
		.RST_VAL (3'h4)
	) u_sync (
		.clk_in  (clk_sys_in),
		.srst_in (srst_in),
		.d_in    ({spi_ss_n_in, spi_sck_in, spi_mosi_in}),
		.q_out   (pin_s)
	);

	// edges come from the synchronised copy
	wire ss_n_s   = pin_s[2];
	wire sck_s    = pin_s[1];
	wire mosi_s   = pin_s[0];
	wire sck_rise = sck_s & ~sck_prev_q;
	wire sck_fall = ~sck_s & sck_prev_q;
	wire ss_fall  = ~ss_n_s & ss_prev_q;

	// leading edge is rising when idle low; cpha moves sampling to trailing
	wire cpol     = transfer_mode_in[SSP_MODE_CPOL];
	wire cpha     = transfer_mode_in[SSP_MODE_CPHA];
	wire lead_ev  = cpol ? sck_fall : sck_rise;
	wire trail_ev = cpol ? sck_rise : sck_fall;
	wire samp_ev  = cpha ? trail_ev : lead_ev;
	wire setup_ev = cpha ? lead_ev : trail_ev;

	wire lsb      = bit_order_select_in == SSP_ORDER_LSB;
	wire buf_mode = buffer_mode_enable_in;
	wire sel      = enable_in & ~ss_n_s;
	wire busy     = st_q == SSP_ST_SHIFT;

	// sampling only while selected, so a deselected port ignores mosi
	wire do_samp   = sel & (st_q != SSP_ST_IDLE) & samp_ev;
	wire byte_done = do_samp & (cnt_q == CNT_LAST);
	wire [DW-1:0] rx_byte = shift_in(sh_q, mosi_s, lsb);

	// write steering
	wire wr_norm   = data_wr_in & ~buf_mode;
	wire collide   = wr_norm & busy;
	wire wr_load   = wr_norm & ~busy;
	wire wr_direct = data_wr_in & buf_mode & buffer_wait_receive_in
		& ss_n_s & ~loaded_q;
	wire wr_buf    = data_wr_in & buf_mode & ~wr_direct;
	wire wr_lost   = wr_buf & txfull_q;
	wire wr_tx     = wr_buf & ~txfull_q;
	wire copy      = byte_done & buf_mode & txfull_q;

	// state machine; a deselect drops back to idle at once
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			SSP_ST_IDLE: begin
				if (sel)
					st_d = SSP_ST_SEL;
			end
			SSP_ST_SEL: begin
				if (do_samp)
					st_d = SSP_ST_SHIFT;
			end
			SSP_ST_SHIFT: begin
				if (byte_done)
					st_d = SSP_ST_SEL;
			end
			default: st_d = SSP_ST_IDLE;
		endcase
		if (!sel)
			st_d = SSP_ST_IDLE;
	end

	// shift register: received byte stays as the next dummy unless a buffer byte waits
	always_comb begin
		sh_d = sh_q;
		if (byte_done)
			sh_d = copy ? txb_q : rx_byte;
		else if (do_samp)
			sh_d = rx_byte;
		else if (wr_load | wr_direct)
			sh_d = data_wdata_in;
	end

	// receive fifo: normal mode holds one byte, buffer mode two; normal mode overwrites it, buffer overflow drops new byte
	always_comb begin
		rx_mem_d = rx_mem_q;
		rx_cnt_d = rx_cnt_q;
		if (data_rd_in && rx_cnt_q != 2'h0) begin
			rx_mem_d[0] = rx_mem_q[1];
			rx_cnt_d    = rx_cnt_q - 2'h1;
		end
		if (byte_done) begin
			if (!buf_mode || rx_cnt_d == 2'h0) begin
				rx_mem_d[0] = rx_byte;
				rx_cnt_d    = 2'h1;
			end else if (rx_cnt_d == 2'h1) begin
				rx_mem_d[1] = rx_byte;
				rx_cnt_d    = 2'h2;
			end
		end
	end

	// flag sources
	always_comb begin
		flag_set             = '0;
		flag_set[SSP_F_DONE] = byte_done & ~buf_mode;
		flag_set[SSP_F_WCOL] = collide;
		flag_set[SSP_F_DRE]  = copy;
		flag_set[SSP_F_RXC]  = done_q1;
		flag_set[SSP_F_TXC]  = done_q2 & empty_q2;
		flag_set[SSP_F_SSI]  = ss_fall & enable_in & buf_mode;
		flag_clr             = flag_clear_in;
		// buffer-empty is owned by hardware: only a buffer write clears it
		flag_clr[SSP_F_DRE]  = wr_tx;
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			sck_prev_q <= 1'b0;
			ss_prev_q  <= 1'b1;
			st_q       <= SSP_ST_IDLE;
		end else begin
			sck_prev_q <= sck_s;
			ss_prev_q  <= ss_n_s;
			st_q       <= st_d;
		end
	end

	// counter clears whenever select is away
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || !sel)
			cnt_q <= '0;
		else if (do_samp)
			cnt_q <= cnt_q + CW'(1);
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			sh_q     <= SSP_DATA_RST;
			txb_q    <= SSP_DATA_RST;
			txfull_q <= 1'b0;
			loaded_q <= 1'b0;
		end else begin
			sh_q <= sh_d;
			if (wr_tx)
				txb_q <= data_wdata_in;
			if (copy)
				txfull_q <= 1'b0;
			else if (wr_tx)
				txfull_q <= 1'b1;
			if (wr_direct | copy)
				loaded_q <= 1'b1;
			else if (byte_done)
				loaded_q <= 1'b0;
		end
	end

	// outgoing bit follows the shifter outside a byte, else moves on setup edges
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			miso_q <= 1'b0;
		else if (!busy || setup_ev)
			miso_q <= out_bit(sh_q, lsb);
	end

	// completion pipeline orders dre, rxc and txc one cycle apart
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			done_q1  <= 1'b0;
			done_q2  <= 1'b0;
			empty_q1 <= 1'b0;
			empty_q2 <= 1'b0;
		end else begin
			done_q1  <= byte_done & buf_mode;
			done_q2  <= done_q1;
			empty_q1 <= ~txfull_q;
			empty_q2 <= empty_q1;
		end
	end

	// a set in the same cycle as its clear wins
	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			flag_q <= SSP_FLAG_RST;
		else
			flag_q <= (flag_q & ~flag_clr) | flag_set;
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rx_mem_q[0] <= SSP_DATA_RST;
			rx_mem_q[1] <= SSP_DATA_RST;
			rx_cnt_q    <= 2'h0;
		end else begin
			rx_mem_q <= rx_mem_d;
			rx_cnt_q <= rx_cnt_d;
		end
	end

	// miso is driven only while selected and configured as output
	assign spi_miso_out    = miso_q;
	assign spi_miso_oe_out = miso_dir_out_in & sel;
	assign data_rdata_out  = rx_mem_q[0];
	assign rx_count_out    = rx_cnt_q;
	assign flags_out       = flag_q;
	// every source shares one request line
	assign irq_out         = |(flag_q & irq_enable_in);

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	sequence s_last_sent;
		byte_done && buf_mode && !txfull_q;
	endsequence

	sequence s_dre_up;
		$rose(flag_q[SSP_F_DRE]) && buf_mode;
	endsequence

	a_deselect_tristate: assert property (
		ss_n_s |-> !spi_miso_oe_out)
		else $error("miso driven while deselected");

	a_deselect_counter: assert property (
		!sel |=> cnt_q == '0 && st_q == SSP_ST_IDLE)
		else $error("counter or state not reset on deselect");

	a_idle_no_shift: assert property (
		(st_q == SSP_ST_IDLE && !data_wr_in) |=> sh_q == $past(sh_q))
		else $error("shift register moved while idle");

	a_done_flag: assert property (
		(byte_done && !buf_mode) |=> flag_q[SSP_F_DONE])
		else $error("transfer done flag not set");

	a_write_collide: assert property (
		(data_wr_in && !buf_mode && busy) |=> flag_q[SSP_F_WCOL])
		else $error("write collision not flagged");

	a_full_keeps_buf: assert property (
		wr_lost |=> txb_q == $past(txb_q) && txfull_q)
		else $error("full transmit buffer overwritten");

	a_dre_on_write: assert property (
		wr_tx |=> !flag_q[SSP_F_DRE] && txfull_q)
		else $error("buffer empty flag not cleared by write");

	a_rxc_after_dre: assert property (
		s_dre_up |=> flag_q[SSP_F_RXC])
		else $error("receive complete not one cycle after empty");

	a_txc_when_drained: assert property (
		s_last_sent |-> ##2 flag_q[SSP_F_RXC] ##1 flag_q[SSP_F_TXC])
		else $error("transfer complete not set after last byte");

	a_direct_load: assert property (
		wr_direct |=> sh_q == $past(data_wdata_in) && loaded_q)
		else $error("direct write missed shift register");

	a_irq_follows: assert property (
		$fell(irq_out) |-> $past(|(flag_q & irq_enable_in & flag_clr))
			|| $past(irq_enable_in) != irq_enable_in)
		else $error("request dropped without clear");

endmodule // ssp_slave

// ### pkg/ssp_pkg.sv
// shared constants for the spi slave port
package ssp_pkg;

	// data path width and receive fifo depth
	localparam int SSP_DW = 8;
	localparam int SSP_RX_DEPTH = 2;

	// transfer mode field bit positions
	localparam int SSP_MODE_CPHA = 0;
	localparam int SSP_MODE_CPOL = 1;

	// bit order select value for lsb first
	localparam logic SSP_ORDER_LSB = 1'b1;

	// sticky flag positions
	localparam int SSP_FLAGS = 6;
	localparam int SSP_F_DONE = 0;
	localparam int SSP_F_WCOL = 1;
	localparam int SSP_F_DRE = 2;
	localparam int SSP_F_RXC = 3;
	localparam int SSP_F_TXC = 4;
	localparam int SSP_F_SSI = 5;

	// reset values
	localparam logic [SSP_FLAGS-1:0] SSP_FLAG_RST = 6'h04;
	localparam logic [SSP_DW-1:0] SSP_DATA_RST = 8'h00;

	// shift state machine
	typedef enum logic [2:0] {
		SSP_ST_IDLE  = 3'b001,
		SSP_ST_SEL   = 3'b010,
		SSP_ST_SHIFT = 3'b100
	} ssp_state_e;

endpackage

// ### hdl/ssp_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ssp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0 // idle level of each pin, held during reset
) (
	input  wire logic         clk_in,  // sampling clock
	input  wire logic         srst_in, // synchronous reset
	input  wire logic [W-1:0] d_in,    // asynchronous inputs
	output logic      [W-1:0] q_out    // synchronised outputs
);
	logic [W-1:0] meta_q;

	// the first stage is read only by the second stage
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			meta_q <= RST_VAL;
			q_out  <= RST_VAL;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule // ssp_sync

// ### bench/ssp_master_model.sv
// behavioural spi master driving the slave port pins
`timescale 1ns/1ps
module ssp_master_model #(
	parameter int HALF_NS = 240 // sck half period, well above two system clocks
) (
	output logic      sck_out,  // spi clock
	output logic      ss_n_out, // slave select, active low
	output logic      mosi_out, // master data
	input  wire logic miso_in   // slave data
);
	initial begin
		sck_out = 1'b0;
		ss_n_out = 1'b1;
		mosi_out = 1'b0;
	end

	// one packet per call; nbits below 8 aborts the byte by raising select
	task automatic xfer(input logic [1:0] m, input logic lsb, input logic [7:0] tx,
			input int nbits, output logic [7:0] rx);
		logic b;
		rx = 8'h00;
		sck_out = m[1];
		#(HALF_NS);
		ss_n_out = 1'b0;
		#(HALF_NS);
		for (int i = 0; i < nbits; i++) begin
			b = lsb ? tx[i] : tx[7-i];
			if (!m[0])
				mosi_out = b;
			#(HALF_NS);
			sck_out = ~m[1];
			if (m[0])
				mosi_out = b;
			else
				rx = lsb ? {miso_in, rx[7:1]} : {rx[6:0], miso_in};
			#(HALF_NS);
			sck_out = m[1];
			if (m[0])
				rx = lsb ? {miso_in, rx[7:1]} : {rx[6:0], miso_in};
		end
		#(HALF_NS);
		ss_n_out = 1'b1;
		// released line: inverse of last value so a stale bit never looks valid
		mosi_out = ~mosi_out;
		#(HALF_NS);
	endtask
endmodule // ssp_master_model

// ### bench/ssp_slave_tb.sv
// self-checking bench for the spi slave port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %s exp %0h got %0h", nm, e, g); end end
module ssp_slave_tb
	import ssp_pkg::*;
;
	logic       clk_sys = 1'b0, srst = 1'b1, dir = 1'b1, en = 1'b1, lsb = 1'b0;
	logic       buffer_mode_enable = 1'b0, buffer_wait_receive = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [1:0] mode = 2'h0, rxcnt;
	logic [7:0] wdata = 8'h00, rdata, rx;
	logic [5:0] clr = 6'h00, ien = 6'h00, flags;
	logic       sck, ss_n, mosi, miso, oe, irq;
	wire        miso_w = oe ? miso : ~miso;
	int         n_mismatch = 0, tests_run = 0, cyc = 0;

	ssp_slave ssp_slave_i (.clk_sys_in(clk_sys), .srst_in(srst), .spi_sck_in(sck),
		.spi_ss_n_in(ss_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
		.spi_miso_oe_out(oe), .miso_dir_out_in(dir), .enable_in(en),
		.transfer_mode_in(mode), .bit_order_select_in(lsb),
		.buffer_mode_enable_in(buffer_mode_enable), .buffer_wait_receive_in(buffer_wait_receive),
		.data_wr_in(wr), .data_wdata_in(wdata), .data_rd_in(rd),
		.data_rdata_out(rdata), .rx_count_out(rxcnt), .flag_clear_in(clr),
		.irq_enable_in(ien), .flags_out(flags), .irq_out(irq));
	ssp_master_model ssp_master_model_i (.sck_out(sck), .ss_n_out(ss_n),
		.mosi_out(mosi), .miso_in(miso_w));

	always #20 clk_sys = ~clk_sys;

	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// every input change lands one ns after a rising edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr_byte(input logic [7:0] d);
		tick(1);
		wdata = d;
		wr = 1'b1;
		tick(1);
		wr = 1'b0;
	endtask
	task automatic pop();
		tick(1);
		rd = 1'b1;
		tick(1);
		rd = 1'b0;
	endtask
	task automatic clr_f(input logic [5:0] m);
		tick(1);
		clr = m;
		tick(1);
		clr = 6'h00;
	endtask
	task automatic run(input logic [7:0] tx, input int n);
		ssp_master_model_i.xfer(mode, lsb, tx, n, rx);
	endtask
	task automatic wait_set(input int idx);
		for (int i = 0; i < 300 && flags[idx] !== 1'b1; i++)
			tick(1);
	endtask

	initial begin
		tick(4);
		srst = 1'b0;
		tick(3);
		`CHK("flags", SSP_FLAG_RST, flags)
		`CHK("oe", 1'b0, oe)
		for (int k = 0; k < 8; k++) begin
			tick(1);
			mode = k[1:0];
			lsb = k[2];
			wr_byte(8'h5a + k[7:0]);
			run(8'hc3 ^ k[7:0], 8);
			tick(4);
			`CHK("rx", 8'h5a + k[7:0], rx)
			`CHK("rdata", 8'hc3 ^ k[7:0], rdata)
			`CHK("done", 1'b1, flags[SSP_F_DONE])
			clr_f(6'h01);
			pop();
		end
		wr_byte(8'h3c);
		fork
			run(8'h96, 8);
			begin
				tick(40);
				`CHK("oe", 1'b1, oe)
				wr_byte(8'he7);
			end
		join
		tick(4);
		`CHK("rx", 8'h3c, rx)
		`CHK("wcol", 1'b1, flags[SSP_F_WCOL])
		clr_f(6'h03);
		pop();
		dir = 1'b0;
		wr_byte(8'h11);
		fork
			run(8'hff, 4);
			begin
				tick(30);
				`CHK("oe", 1'b0, oe)
			end
		join
		tick(4);
		dir = 1'b1;
		`CHK("done", 1'b0, flags[SSP_F_DONE])
		wr_byte(8'h22);
		run(8'h81, 8);
		tick(4);
		`CHK("rdata", 8'h81, rdata)
		`CHK("rx", 8'h22, rx)
		clr_f(6'h01);
		pop();
		buffer_mode_enable = 1'b1;
		ien = 6'h08;
		wr_byte(8'h43);
		`CHK("dre", 1'b0, flags[SSP_F_DRE])
		wr_byte(8'h45); // buffer full, dropped
		fork
			run(8'h01, 8);
			begin
				wait_set(SSP_F_DRE);
				`CHK("rxc", 1'b0, flags[SSP_F_RXC])
				tick(1);
				`CHK("rxc", 1'b1, flags[SSP_F_RXC])
				`CHK("irq", 1'b1, irq)
				tick(1);
				`CHK("txc", 1'b0, flags[SSP_F_TXC])
			end
		join
		`CHK("dummy", 8'h81, rx)
		`CHK("ssi", 1'b1, flags[SSP_F_SSI])
		clr_f(6'h08);
		`CHK("irq", 1'b0, irq)
		run(8'h02, 8);
		tick(4);
		`CHK("rx", 8'h43, rx)
		`CHK("txc", 1'b1, flags[SSP_F_TXC])
		`CHK("cnt", 2'h2, rxcnt)
		`CHK("rdata", 8'h01, rdata)
		pop();
		`CHK("rdata", 8'h02, rdata)
		pop();
		clr_f(6'h3b);
		buffer_wait_receive = 1'b1;
		wr_byte(8'h44);
		wr_byte(8'h46);
		run(8'h03, 8);
		tick(4);
		`CHK("rx", 8'h44, rx)
		run(8'h04, 8);
		tick(4);
		`CHK("rx", 8'h46, rx)
		report_and_stop();
	end
endmodule // ssp_slave_tb
